// File: src/logic_step_defs.svh
// Shared constants for the logic step: codes, offsets, field positions and timing.
`ifndef LOGIC_STEP_DEFS_SVH
`define LOGIC_STEP_DEFS_SVH

// Input selection codes and their range limits, given in hex.
`define SEL_GP_LAST 16'h00EB
`define SEL_UNIVERSAL_DO 16'h001B
`define SEL_BLOCKED_LO 16'h006F
`define SEL_BLOCKED_HI 16'h0075
`define SEL_INVERT_OFFSET 16'h03E8
`define SEL_GP_INV_LO 16'h03E8
`define SEL_GP_INV_HI 16'h04D3
`define SEL_STEP_LO 16'h07D1
`define SEL_STEP_HI 16'h07DE
`define SEL_STEP_INV_LO 16'h0BB9
`define SEL_STEP_INV_HI 16'h0BC6
`define SEL_TERM_LO 16'h0FA1
`define SEL_TERM_HI 16'h0FA7
`define SEL_TERM_FWD 16'h0FAA
`define SEL_TERM_REV 16'h0FAB
`define SEL_TERM_INV_LO 16'h1389
`define SEL_TERM_INV_HI 16'h1393
`define SEL_RUN 16'h1770
`define SEL_FWD_RUN 16'h1771
`define SEL_REV_RUN 16'h1772
`define SEL_ACCEL 16'h1773
`define SEL_DECEL 16'h1774
`define SEL_ANTIREGEN 16'h1775
`define SEL_ALARM 16'h1777
`define SEL_STATE_INV_LO 16'h1B58
`define SEL_STATE_INV_HI 16'h1B5F

// Terminal bit positions inside the terminal vector.
`define TERM_FWD_BIT 7
`define TERM_REV_BIT 8

// Logic element codes (10, 15, 20, 25, 30, 35, 40, 45, 50, 55, 60, 65, 70, 73, 80, 83, 90, 93,
// 110, 120, 130) and the edge-group member that is not available (x1).
`define EL_THROUGH_LO 8'h0A
`define EL_THROUGH_HI 8'h0F
`define EL_AND_LO 8'h14
`define EL_AND_HI 8'h19
`define EL_OR_LO 8'h1E
`define EL_OR_HI 8'h23
`define EL_XOR_LO 8'h28
`define EL_XOR_HI 8'h2D
`define EL_SET_LO 8'h32
`define EL_SET_HI 8'h37
`define EL_RESET_LO 8'h3C
`define EL_RESET_HI 8'h41
`define EL_RISE_LO 8'h46
`define EL_RISE_HI 8'h49
`define EL_FALL_LO 8'h50
`define EL_FALL_HI 8'h53
`define EL_BOTH_LO 8'h5A
`define EL_BOTH_HI 8'h5D
`define EL_EDGE_SKIP 8'h01
`define EL_INC 8'h6E
`define EL_DEC 8'h78
`define EL_TIMER 8'h82

// Register byte offsets on the AXI4-Lite bus.
`define REG_SEL1 8'h00
`define REG_SEL2 8'h04
`define REG_ELEMENT 8'h08
`define REG_TARGET 8'h0C
`define REG_STATUS 8'h10

// Status word fields.
`define STAT_OUT_BIT 0
`define STAT_IN1_BIT 1
`define STAT_IN2_BIT 2
`define STAT_SEL1_BAD_BIT 3
`define STAT_SEL2_BAD_BIT 4
`define STAT_ELEM_BAD_BIT 5
`define STAT_COUNT_LSB 16

// AXI response codes.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing: edge pulse length, timer unit and clock rate.
`define EDGE_PULSE_MS 5
`define TIMER_UNIT_MS 1
`define CLOCK_KHZ 100000

`endif

// File: src/logic_step_pkg.sv
// Types shared by the logic step modules.
package logic_step_pkg;

  // Drive state signals that the selector can route.
  typedef struct packed {
    logic freq_nonzero;
    logic run_cmd;
    logic forward_cmd;
    logic backward_cmd;
    logic accelerating;
    logic decelerating;
    logic antiregen;
    logic alarm_present;
  } drive_status_t;

  // Logic element kinds decoded from the element code.
  typedef enum logic [3:0] {
    EL_OFF = 4'b0000,
    EL_THROUGH = 4'b0001,
    EL_AND = 4'b0010,
    EL_OR = 4'b0011,
    EL_XOR = 4'b0100,
    EL_SET_FF = 4'b0101,
    EL_RESET_FF = 4'b0110,
    EL_RISE = 4'b0111,
    EL_FALL = 4'b1000,
    EL_BOTH = 4'b1001,
    EL_INC = 4'b1010,
    EL_DEC = 4'b1011,
    EL_TIMER = 4'b1100
  } element_kind_t;

endpackage

// File: src/input_select_mux.sv
// Routes one drive signal to a step input by its numeric selection code.
`timescale 1ns/1ps
`include "logic_step_defs.svh"

module input_select_mux (
  // Selection code
  input wire logic [15:0] code,
  // Candidate sources
  input wire logic [235:0] gp_status,
  input wire logic [13:0] step_outputs,
  input wire logic [8:0] terminals,
  input wire logic_step_pkg::drive_status_t drive,
  // Result
  output logic selected,
  output logic code_bad
);

  logic invert;
  logic value;
  logic [15:0] base;
  logic [15:0] idx;

  // Strips the inverting offset, then decodes the base code into a source.
  always_comb begin
    invert = 1'b0;
    base = code;
    idx = 16'h0000;
    value = 1'b0;
    code_bad = 1'b0;
    if ((code >= `SEL_GP_INV_LO && code <= `SEL_GP_INV_HI) ||
        (code >= `SEL_STEP_INV_LO && code <= `SEL_STEP_INV_HI) ||
        (code >= `SEL_TERM_INV_LO && code <= `SEL_TERM_INV_HI) ||
        (code >= `SEL_STATE_INV_LO && code <= `SEL_STATE_INV_HI)) begin
      invert = 1'b1;
      base = code - `SEL_INVERT_OFFSET;
    end
    if (base <= `SEL_GP_LAST) begin
      if (base == `SEL_UNIVERSAL_DO) begin
        code_bad = 1'b1;
      end else if (base >= `SEL_BLOCKED_LO && base <= `SEL_BLOCKED_HI) begin
        code_bad = 1'b1;
      end else begin
        value = gp_status[base[7:0]];
      end
    end else if (base >= `SEL_STEP_LO && base <= `SEL_STEP_HI) begin
      idx = base - `SEL_STEP_LO;
      value = step_outputs[idx[3:0]];
    end else if (base >= `SEL_TERM_LO && base <= `SEL_TERM_HI) begin
      idx = base - `SEL_TERM_LO;
      value = terminals[idx[3:0]];
    end else if (base == `SEL_TERM_FWD) begin
      value = terminals[`TERM_FWD_BIT];
    end else if (base == `SEL_TERM_REV) begin
      value = terminals[`TERM_REV_BIT];
    end else if (base == `SEL_RUN) begin
      value = drive.freq_nonzero & drive.run_cmd;
    end else if (base == `SEL_FWD_RUN) begin
      value = drive.freq_nonzero & drive.forward_cmd;
    end else if (base == `SEL_REV_RUN) begin
      value = drive.freq_nonzero & drive.backward_cmd;
    end else if (base == `SEL_ACCEL) begin
      value = drive.accelerating;
    end else if (base == `SEL_DECEL) begin
      value = drive.decelerating;
    end else if (base == `SEL_ANTIREGEN) begin
      value = drive.antiregen;
    end else if (base == `SEL_ALARM) begin
      value = ~drive.alarm_present;
    end else begin
      code_bad = 1'b1;
    end
    selected = code_bad ? 1'b0 : (value ^ invert);
  end

endmodule

// File: src/edge_pulse_timer.sv
// Holds its output high for a fixed number of cycles after each trigger.
`timescale 1ns/1ps

module edge_pulse_timer #(
  parameter int PULSE_CYCLES = 500000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Trigger and pulse
  input wire logic trigger,
  output logic active
);

  localparam int CW = $clog2(PULSE_CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(PULSE_CYCLES);

  logic [CW-1:0] remain;
  logic [CW-1:0] next_remain;

  // A new edge restarts the full length; otherwise the count runs down.
  always_comb begin
    next_remain = remain;
    if (trigger) begin
      next_remain = LOAD;
    end else if (remain != '0) begin
      next_remain = remain - 1'b1;
    end
  end

  // Registers the remaining length.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      remain <= '0;
    end else begin
      remain <= next_remain;
    end
  end

  assign active = (remain != '0);

endmodule

// File: src/logic_step_input_select.sv
// One logic step: two selected inputs, a chosen logic element and an AXI4-Lite register file.
`timescale 1ns/1ps
`include "logic_step_defs.svh"

module logic_step_input_select #(
  parameter int ADDR_WIDTH = 8,
  parameter int COUNT_WIDTH = 16,
  parameter int EDGE_PULSE_CYCLES = `EDGE_PULSE_MS * `CLOCK_KHZ,
  parameter int TIMER_UNIT_CYCLES = `TIMER_UNIT_MS * `CLOCK_KHZ
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // AXI4-Lite write address and data
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Signal sources
  input wire logic [235:0] gp_status,
  input wire logic [13:0] step_outputs,
  input wire logic [8:0] terminal_pins,
  input wire logic_step_pkg::drive_status_t drive_status,
  // Step result
  output logic step_output
);

  localparam int TW = $clog2(TIMER_UNIT_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TIMER_UNIT_CYCLES - 1);

  // Register file state.
  logic [15:0] first_input_select;
  logic [15:0] second_input_select;
  logic [7:0] element_code;
  logic [COUNT_WIDTH-1:0] target;
  logic [15:0] next_first_input_select;
  logic [15:0] next_second_input_select;
  logic [7:0] next_element_code;
  logic [COUNT_WIDTH-1:0] next_target;

  // Write channel state.
  logic aw_held;
  logic w_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic next_aw_held;
  logic next_w_held;
  logic [ADDR_WIDTH-1:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;

  // Read channel state.
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Terminal synchronisers and filtered levels.
  logic [8:0] term_s1;
  logic [8:0] term_s2;
  logic [8:0] term_s3;
  logic [8:0] terminals;
  logic [8:0] next_terminals;

  // Logic element state.
  logic in1;
  logic in2;
  logic sel1_bad;
  logic sel2_bad;
  logic in1_prev;
  logic out_q;
  logic [COUNT_WIDTH-1:0] count;
  logic [COUNT_WIDTH-1:0] elapsed;
  logic timer_on;
  logic [TW-1:0] tick_cnt;
  logic next_in1_prev;
  logic next_out_q;
  logic [COUNT_WIDTH-1:0] next_count;
  logic [COUNT_WIDTH-1:0] next_elapsed;
  logic next_timer_on;
  logic [TW-1:0] next_tick_cnt;
  logic unit_tick;
  logic rise1;
  logic edge_trigger;
  logic edge_active;
  logic_step_pkg::element_kind_t kind;

  // Merges a 16-bit field with the low two byte lanes of a write.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Maps an element code onto its kind; unknown codes give the off kind.
  function automatic logic_step_pkg::element_kind_t decode_element(input logic [7:0] c);
    logic_step_pkg::element_kind_t k;
    k = logic_step_pkg::EL_OFF;
    if (c >= `EL_THROUGH_LO && c <= `EL_THROUGH_HI) begin
      k = logic_step_pkg::EL_THROUGH;
    end else if (c >= `EL_AND_LO && c <= `EL_AND_HI) begin
      k = logic_step_pkg::EL_AND;
    end else if (c >= `EL_OR_LO && c <= `EL_OR_HI) begin
      k = logic_step_pkg::EL_OR;
    end else if (c >= `EL_XOR_LO && c <= `EL_XOR_HI) begin
      k = logic_step_pkg::EL_XOR;
    end else if (c >= `EL_SET_LO && c <= `EL_SET_HI) begin
      k = logic_step_pkg::EL_SET_FF;
    end else if (c >= `EL_RESET_LO && c <= `EL_RESET_HI) begin
      k = logic_step_pkg::EL_RESET_FF;
    end else if (c >= `EL_RISE_LO && c <= `EL_RISE_HI && c != `EL_RISE_LO + `EL_EDGE_SKIP) begin
      k = logic_step_pkg::EL_RISE;
    end else if (c >= `EL_FALL_LO && c <= `EL_FALL_HI && c != `EL_FALL_LO + `EL_EDGE_SKIP) begin
      k = logic_step_pkg::EL_FALL;
    end else if (c >= `EL_BOTH_LO && c <= `EL_BOTH_HI && c != `EL_BOTH_LO + `EL_EDGE_SKIP) begin
      k = logic_step_pkg::EL_BOTH;
    end else if (c == `EL_INC) begin
      k = logic_step_pkg::EL_INC;
    end else if (c == `EL_DEC) begin
      k = logic_step_pkg::EL_DEC;
    end else if (c == `EL_TIMER) begin
      k = logic_step_pkg::EL_TIMER;
    end
    return k;
  endfunction

  // Write path: address and data are taken in either order, then the write and response.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_first_input_select = first_input_select;
    next_second_input_select = second_input_select;
    next_element_code = element_code;
    next_target = target;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      if (aw_addr[7:0] == `REG_SEL1) begin
        next_first_input_select = merge16(first_input_select, w_data, w_strb);
      end else if (aw_addr[7:0] == `REG_SEL2) begin
        next_second_input_select = merge16(second_input_select, w_data, w_strb);
      end else if (aw_addr[7:0] == `REG_ELEMENT) begin
        if (w_strb[0]) begin
          next_element_code = w_data[7:0];
        end
      end else if (aw_addr[7:0] == `REG_TARGET) begin
        next_target = COUNT_WIDTH'(merge16(16'(target), w_data, w_strb));
      end else if (aw_addr[7:0] == `REG_STATUS) begin
        next_bresp = `RESP_OKAY;
      end else begin
        next_bresp = `RESP_SLVERR;
      end
    end
  end

  // Registers the write path and the register file.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      first_input_select <= 16'h0000;
      second_input_select <= 16'h0000;
      element_code <= 8'h00;
      target <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      first_input_select <= next_first_input_select;
      second_input_select <= next_second_input_select;
      element_code <= next_element_code;
      target <= next_target;
    end
  end

  // Read path: one read at a time, data captured when the address is taken.
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end else if (!rvalid && s_axi_arvalid) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr[7:0] == `REG_SEL1) begin
        next_rdata[15:0] = first_input_select;
      end else if (s_axi_araddr[7:0] == `REG_SEL2) begin
        next_rdata[15:0] = second_input_select;
      end else if (s_axi_araddr[7:0] == `REG_ELEMENT) begin
        next_rdata[7:0] = element_code;
      end else if (s_axi_araddr[7:0] == `REG_TARGET) begin
        next_rdata[COUNT_WIDTH-1:0] = target;
      end else if (s_axi_araddr[7:0] == `REG_STATUS) begin
        next_rdata[`STAT_OUT_BIT] = out_q;
        next_rdata[`STAT_IN1_BIT] = in1;
        next_rdata[`STAT_IN2_BIT] = in2;
        next_rdata[`STAT_SEL1_BAD_BIT] = sel1_bad;
        next_rdata[`STAT_SEL2_BAD_BIT] = sel2_bad;
        next_rdata[`STAT_ELEM_BAD_BIT] = (kind == logic_step_pkg::EL_OFF);
        next_rdata[`STAT_COUNT_LSB +: COUNT_WIDTH] = count;
      end else begin
        next_rresp = `RESP_SLVERR;
      end
    end
  end

  // Registers the read path.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Bus handshake outputs.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // A terminal level changes only once the second and third stages agree.
  always_comb begin
    next_terminals = ((term_s2 ~^ term_s3) & term_s3) | ((term_s2 ^ term_s3) & terminals);
  end

  // Three-stage synchroniser for the asynchronous terminal pins.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      term_s1 <= 9'h000;
      term_s2 <= 9'h000;
      term_s3 <= 9'h000;
      terminals <= 9'h000;
    end else begin
      term_s1 <= terminal_pins;
      term_s2 <= term_s1;
      term_s3 <= term_s2;
      terminals <= next_terminals;
    end
  end

  // Input 1 selector.
  input_select_mux first_mux (
    .code(first_input_select),
    .gp_status(gp_status),
    .step_outputs(step_outputs),
    .terminals(terminals),
    .drive(drive_status),
    .selected(in1),
    .code_bad(sel1_bad)
  );

  // Input 2 selector.
  input_select_mux second_mux (
    .code(second_input_select),
    .gp_status(gp_status),
    .step_outputs(step_outputs),
    .terminals(terminals),
    .drive(drive_status),
    .selected(in2),
    .code_bad(sel2_bad)
  );

  // Element kind and edge trigger for the pulse stretcher.
  always_comb begin
    kind = decode_element(element_code);
    rise1 = in1 & ~in1_prev;
    unit_tick = (tick_cnt == TICK_LAST);
    case (kind)
      logic_step_pkg::EL_RISE: edge_trigger = rise1;
      logic_step_pkg::EL_FALL: edge_trigger = ~in1 & in1_prev;
      logic_step_pkg::EL_BOTH: edge_trigger = in1 ^ in1_prev;
      default: edge_trigger = 1'b0;
    endcase
  end

  // Stretches each detected edge to the fixed pulse length.
  edge_pulse_timer #(
    .PULSE_CYCLES(EDGE_PULSE_CYCLES)
  ) edge_pulse (
    .clock(clock),
    .sys_rst(sys_rst),
    .trigger(edge_trigger),
    .active(edge_active)
  );

  // Element next state: one evaluation per clock.
  always_comb begin
    next_in1_prev = in1;
    next_out_q = out_q;
    next_count = count;
    next_elapsed = elapsed;
    next_timer_on = timer_on;
    next_tick_cnt = unit_tick ? '0 : tick_cnt + 1'b1;
    case (kind)
      logic_step_pkg::EL_THROUGH: next_out_q = in1;
      logic_step_pkg::EL_AND: next_out_q = in1 & in2;
      logic_step_pkg::EL_OR: next_out_q = in1 | in2;
      logic_step_pkg::EL_XOR: next_out_q = in1 ^ in2;
      logic_step_pkg::EL_SET_FF: begin
        if (in1) begin
          next_out_q = 1'b1;
        end else if (in2) begin
          next_out_q = 1'b0;
        end
      end
      logic_step_pkg::EL_RESET_FF: begin
        if (in2) begin
          next_out_q = 1'b0;
        end else if (in1) begin
          next_out_q = 1'b1;
        end
      end
      logic_step_pkg::EL_RISE, logic_step_pkg::EL_FALL, logic_step_pkg::EL_BOTH: begin
        next_out_q = edge_active | edge_trigger;
      end
      logic_step_pkg::EL_INC: begin
        if (in2) begin
          next_count = '0;
        end else if (rise1 && count < target) begin
          next_count = count + 1'b1;
        end
        next_out_q = (next_count == target);
      end
      logic_step_pkg::EL_DEC: begin
        if (in2) begin
          next_count = target;
        end else if (rise1 && count != '0) begin
          next_count = count - 1'b1;
        end
        next_out_q = (next_count == '0);
      end
      logic_step_pkg::EL_TIMER: begin
        if (in2) begin
          next_timer_on = 1'b0;
          next_elapsed = '0;
        end else if (rise1) begin
          next_timer_on = 1'b1;
          next_elapsed = '0;
        end else if (timer_on && elapsed >= target) begin
          next_timer_on = 1'b0;
        end else if (timer_on && unit_tick) begin
          next_elapsed = elapsed + 1'b1;
        end
        next_out_q = next_timer_on;
      end
      default: next_out_q = 1'b0;
    endcase
  end

  // Registers the element state; reset clears outputs and counts.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      in1_prev <= 1'b0;
      out_q <= 1'b0;
      count <= '0;
      elapsed <= '0;
      timer_on <= 1'b0;
      tick_cnt <= '0;
    end else begin
      in1_prev <= next_in1_prev;
      out_q <= next_out_q;
      count <= next_count;
      elapsed <= next_elapsed;
      timer_on <= next_timer_on;
      tick_cnt <= next_tick_cnt;
    end
  end

  assign step_output = out_q;

endmodule

// File: tb/logic_step_monitor.sv
// Bus and reset checks for the logic step.
`timescale 1ns/1ps
`include "logic_step_defs.svh"
module logic_step_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Step result
  input wire logic step_output
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Handshake timing and answer stability.
  a_reset_idle: assert property (disable iff (1'b0)
    sys_rst |=> !s_axi_bvalid && !s_axi_rvalid && !step_output) else $error("not idle after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
  a_read_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write answer moved");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == `RESP_OKAY ||
    s_axi_bresp == `RESP_SLVERR) else $error("bad write response");
  // Main traffic seen.
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_out: cover property ($rose(step_output));
endmodule
bind logic_step_input_select logic_step_monitor mon (.clock(clock), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .step_output(step_output));

// File: tb/logic_step_input_select_tb.sv
// Self-checking bench for the logic step.
`timescale 1ns/1ps
`include "logic_step_defs.svh"
module logic_step_input_select_tb;
  logic clock = 0, sys_rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, pa, pw, pb, o;
  logic awr, wrd, bv, arr, rv, so;
  logic [1:0] br, rr, e;
  logic [31:0] wd = 0, rdat, r;
  logic [7:0] awa = 0, ara = 0;
  logic [235:0] gp = 0;
  logic [13:0] sp = 0;
  logic [8:0] tp = 0;
  logic_step_pkg::drive_status_t ds = 0;
  logic [33:0] eq[$], mq[$];
  int seed = 32'h9D8C16CF, n_errors = 0, check_count = 0, n;
  int codes[] = '{0, 235, 27, 111, 117, 1111, 1117, 1005, 1235, 2001, 2014, 3007, 4001, 4007,
    4010, 4011, 5001, 5011, 6000, 6001, 6002, 6003, 6004, 6005, 6007, 7000, 7005, 7007};
  logic [1:0] pat[] = '{2'b01, 2'b00, 2'b11, 2'b00, 2'b10, 2'b00, 2'b11};
  logic_step_input_select #(.EDGE_PULSE_CYCLES(20), .TIMER_UNIT_CYCLES(10)) uut (
    .clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .gp_status(gp),
    .step_outputs(sp), .terminal_pins(tp), .drive_status(ds), .step_output(so));
  // Free-running clock.
  initial forever #5 clock = ~clock;
  task automatic check(input string nm, input logic [33:0] s, input logic [33:0] x);
    check_count++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
    eq.push_back({x, 32'h0});
    mq.push_back(34'h300000000);
    @(posedge clock);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    pa = 1;
    pw = 1;
    pb = 1;
    while (pb) begin
      @(posedge clock);
      if (pa && awr) begin awv <= 1'b0; pa = 0; end
      if (pw && wrd) begin wv <= 1'b0; pw = 0; end
      if (bv) begin bry <= 1'b0; pb = 0; end
    end
  endtask
  task rd(input logic [7:0] a, input logic [33:0] x, input logic [33:0] m);
    eq.push_back(x);
    mq.push_back(m);
    @(posedge clock);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    pa = 1;
    pb = 1;
    while (pb) begin
      @(posedge clock);
      if (pa && arr) begin arv <= 1'b0; pa = 0; end
      if (rv) begin rry <= 1'b0; pb = 0; end
    end
  endtask
  task st(input logic [33:0] x, input logic [33:0] m);
    repeat (8) @(posedge clock);
    rd(`REG_STATUS, x, m);
  endtask
  // Expected step input and refusal flag for a selection code.
  function logic [1:0] ref_in(input int c);
    int b;
    logic v;
    b = c;
    v = 1'b0;
    if (c inside {[1000:1235], [3001:3014], [5001:5011], [7000:7007]}) b = c - 1000;
    case (b) inside
      [0:235]: v = gp[b];
      [2001:2014]: v = sp[b - 2001];
      [4001:4007]: v = tp[b - 4001];
      4010: v = tp[7];
      4011: v = tp[8];
      6000: v = ds.freq_nonzero & ds.run_cmd;
      6001: v = ds.freq_nonzero & ds.forward_cmd;
      6002: v = ds.freq_nonzero & ds.backward_cmd;
      6003: v = ds.accelerating;
      6004: v = ds.decelerating;
      6005: v = ds.antiregen;
      6007: v = !ds.alarm_present;
    endcase
    if (b inside {27, [111:117]}) return 2'b10;
    return {1'b0, b != c ? !v : v};
  endfunction
  // Compares each bus answer with the oldest expectation.
  always @(posedge clock) begin
    if (bv && bry || rv && rry) begin
      check("bus", (bv ? {br, 32'h0} : {rr, rdat}) & mq.pop_front(), eq.pop_front());
    end
  end
  // Cuts a hung run short.
  initial begin
    #400000;
    n_errors++;
    close_out;
  end
  // Main sequence.
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(`REG_SEL1, 34'h0, 34'h3FFFFFFFF);
    rd(`REG_STATUS, 34'h20, 34'h300000021);
    rd(8'h14, {`RESP_SLVERR, 32'h0}, 34'h3FFFFFFFF);
    wr(8'h14, 32'h1, `RESP_SLVERR);
    foreach (codes[i]) repeat (2) begin
      wr(`REG_SEL1, 32'(codes[i]), `RESP_OKAY);
      r = $random(seed);
      for (int k = 0; k < 236; k++) gp[k] <= r[k % 32] ^ k[0];
      sp <= r[13:0];
      tp <= r[22:14];
      ds <= r[31:24];
      repeat (8) @(posedge clock);
      e = ref_in(codes[i]);
      st({30'h0, e[1], 1'b0, e[0], 1'b0}, 34'h30000000A);
    end
    wr(`REG_SEL1, 32'h0FA1, `RESP_OKAY);
    wr(`REG_SEL2, 32'h0FA2, `RESP_OKAY);
    for (int j = 0; j < 2; j++) begin
      wr(`REG_ELEMENT, j ? 32'h3C : 32'h32, `RESP_OKAY);
      foreach (pat[i]) begin
        tp <= {7'h0, pat[i]};
        if (pat[i] == 2'b11) o = !j;
        else if (pat[i] != 2'b00) o = pat[i][0];
        st({33'h0, o}, 34'h300000001);
      end
    end
    wr(`REG_ELEMENT, 32'h5A, `RESP_OKAY);
    repeat (2) begin
      tp[0] <= !tp[0];
      n = 0;
      repeat (60) begin @(posedge clock); n += so; end
      check("pulse", 34'(n), 34'd21);
    end
    wr(`REG_TARGET, 32'h3, `RESP_OKAY);
    wr(`REG_ELEMENT, 32'h6E, `RESP_OKAY);
    tp <= 9'h002;
    st(34'h0, 34'h3FFFF0001);
    for (int i = 1; i <= 3; i++) begin
      tp <= 9'h001;
      repeat (8) @(posedge clock);
      tp <= 9'h000;
      st({2'b0, 16'(i), 15'h0, i == 3}, 34'h3FFFF0001);
    end
    wr(`REG_ELEMENT, 32'h82, `RESP_OKAY);
    tp <= 9'h001;
    st(34'h1, 34'h300000001);
    repeat (40) @(posedge clock);
    st(34'h0, 34'h300000001);
    close_out;
  end
endmodule
